//--- design/wdog_pkg.sv
// Shared constants, types and register layout of the watchdog and oscillator monitor
package wdog_pkg;

	// Register map, byte addresses on the plain register port
	localparam logic [7:0] ADDR_CTRL   = 8'hc0;
	localparam logic [7:0] ADDR_RELOAD = 8'h86;

	// Field positions inside the control/status register
	localparam int BIT_START      = 0;
	localparam int BIT_REFRESH    = 1;
	localparam int BIT_TIMER_FLAG = 2;
	localparam int BIT_OSC_FLAG   = 3;
	// Field positions inside the reload register
	localparam int BIT_PSEL       = 7;

	// Reset values
	localparam logic [7:0]  RELOAD_RST = 8'h00;
	localparam logic [7:0]  LOW_START  = 8'h00;
	localparam logic [14:0] COUNT_RST  = 15'h0000;

	// Watchdog timing
	localparam logic [14:0] WD_TRIP      = 15'h7ffc;
	localparam logic [7:0]  WD_RST_FAST  = 8'h08;
	localparam logic [7:0]  WD_RST_SLOW  = 8'h80;
	localparam logic [1:0]  REFRESH_LIFE = 2'h2;
	localparam int          PSC_SLOW     = 16;
	localparam int          PSC_W        = 4;
	localparam int          RC_DIV       = 10;
	localparam int          RC_DIV_W     = 4;

	// Oscillator monitor timing at a 4 ns system clock
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int RECOVER_TIME_MS = 1;
	localparam int RECOVER_CYC     = RECOVER_TIME_MS * 1000000000 / CLK_PERIOD_PS;
	localparam int SETTLE_W        = 18;

	// Oscillator monitor states
	typedef enum logic [4:0] {
		MON_FAIL        = 5'b00001,
		MON_SETTLE      = 5'b00010,
		MON_RUN         = 5'b00100,
		MON_PDOWN       = 5'b01000,
		MON_WAKE_WAIT   = 5'b10000
	} mon_e;

	// One register-port access
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	// Whole state of the top module
	typedef struct packed {
		mon_e                mon;
		logic                wake_settle;
		logic [SETTLE_W-1:0] settle_cnt;
		logic                running;
		logic [14:0]         count;
		logic [7:0]          reload;
		logic                refresh;
		logic [1:0]          refresh_age;
		logic                timer_flag;
		logic                osc_flag;
		logic                wd_rst;
		logic [7:0]          wd_rst_cnt;
		logic [7:0]          wd_rst_len;
		logic                sys_reset;
		logic                clk_sel_rc;
		logic                osc_stop;
		logic                wake_hold;
		logic [7:0]          rdata;
	} wdog_state_s;

endpackage

//--- design/tick_divider.sv
// Divides a stream of single-cycle ticks by a fixed ratio
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIV = 10,
	parameter int W   = 4
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_en_i,
	// Tick stream
	input  wire logic clr_i,
	input  wire logic tick_i,
	output logic      tick_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} div_state_s;

	div_state_s s_r;
	div_state_s s_nxt;

	// Count input ticks, emit one output tick every DIV of them
	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		if (clr_i) begin
			s_nxt.cnt = '0;
		end else if (tick_i) begin
			if (s_r.cnt == W'(DIV - 1)) begin
				s_nxt.cnt  = '0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + W'(1);
			end
		end
	end

	// Frozen while the clock enable is low
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;
endmodule

//--- design/osc_compare.sv
// Flags a main oscillator slower than the divided RC reference
`timescale 1ns/1ps
module osc_compare (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_en_i,
	// Oscillator ticks
	input  wire logic restart_i,
	input  wire logic ref_tick_i,
	input  wire logic main_tick_i,
	output logic      fail_o
);
	typedef struct packed {
		logic seen;
		logic fail;
	} cmp_state_s;

	cmp_state_s s_r;
	cmp_state_s s_nxt;

	// No main tick during one reference period means failure
	always_comb begin
		s_nxt = s_r;
		if (restart_i) begin
			s_nxt.seen = 1'b0;
			s_nxt.fail = 1'b1;
		end else if (ref_tick_i) begin
			s_nxt.fail = !(s_r.seen || main_tick_i);
			s_nxt.seen = 1'b0;
		end else if (main_tick_i) begin
			s_nxt.seen = 1'b1;
		end
	end

	// Fail at power-on: the main oscillator has not started yet
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '{seen: 1'b0, fail: 1'b1};
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	assign fail_o = s_r.fail;
endmodule

//--- design/watchdog_and_osc_monitor.sv
// Programmable watchdog timer and oscillator monitor with register port
`timescale 1ns/1ps
module watchdog_and_osc_monitor import wdog_pkg::*; #(
	parameter int RECOVER_CYCLES = wdog_pkg::RECOVER_CYC
) (
	// Clock, reset, clock enable
	input  wire logic             sys_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             clk_en_i,
	// Register port
	input  wire wdog_pkg::bus_req_s bus_i,
	output logic [7:0]            rdata_o,
	// Core timing and power state
	input  wire logic             mcycle_i,
	input  wire logic             idle_i,
	input  wire logic             powerdown_i,
	input  wire logic             wake_i,
	input  wire logic             ext_reset_i,
	// Oscillator ticks
	input  wire logic             osc_tick_i,
	input  wire logic             rc_tick_i,
	// Reset and clock control
	output logic                  sys_reset_o,
	output logic                  clk_sel_rc_o,
	output logic                  osc_stop_o,
	output logic                  wake_hold_o
);
	import wdog_pkg::*;

	localparam wdog_state_s ST_RST = '{mon: MON_FAIL, sys_reset: 1'b1, clk_sel_rc: 1'b1, default: '0};

	wdog_state_s s_r;
	wdog_state_s s_nxt;
	logic        ref_tick;
	logic        osc_fail;
	logic        psc_tick;
	logic        psc_clr;
	logic        halt;
	logic        cnt_tick;
	logic        wr_ctrl;
	logic        wr_rel;
	logic        osc_rst;
	logic        mon_restart;

	// Divided RC reference and frequency check
	tick_divider #(.DIV(RC_DIV), .W(RC_DIV_W)) u_rc_div (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.clr_i     (mon_restart),
		.tick_i    (rc_tick_i),
		.tick_o    (ref_tick)
	);

	osc_compare u_cmp (
		.sys_clk_i   (sys_clk_i),
		.rstn_i      (rstn_i),
		.clk_en_i    (clk_en_i),
		.restart_i   (mon_restart),
		.ref_tick_i  (ref_tick),
		.main_tick_i (osc_tick_i),
		.fail_o      (osc_fail)
	);

	// Slow prescaler, counts machine cycles only while the timer advances
	tick_divider #(.DIV(PSC_SLOW), .W(PSC_W)) u_psc (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.clr_i     (psc_clr),
		.tick_i    (mcycle_i && s_r.running && !halt && !s_r.wd_rst),
		.tick_o    (psc_tick)
	);

	// Decodes and shared conditions
	assign wr_ctrl     = bus_i.wr && (bus_i.addr == ADDR_CTRL);
	assign wr_rel      = bus_i.wr && (bus_i.addr == ADDR_RELOAD);
	assign halt        = idle_i || powerdown_i;
	assign cnt_tick    = s_r.reload[BIT_PSEL] ? psc_tick : mcycle_i;
	assign osc_rst     = (s_r.mon == MON_FAIL) || ((s_r.mon == MON_SETTLE) && !s_r.wake_settle);
	assign mon_restart = (s_r.mon == MON_PDOWN);

	// Next state of the whole block
	always_comb begin
		s_nxt         = s_r;
		s_nxt.rdata   = 8'h00;
		psc_clr       = 1'b0;

		// Refresh request ages out on machine cycles
		if (s_r.refresh && mcycle_i) begin
			if (s_r.refresh_age == REFRESH_LIFE) begin
				s_nxt.refresh = 1'b0;
			end else begin
				s_nxt.refresh_age = s_r.refresh_age + 2'h1;
			end
		end

		// Reload value may change even while counting
		if (wr_rel) begin
			s_nxt.reload = bus_i.wdata;
		end

		// Control writes; a zero start bit never stops the timer
		if (wr_ctrl) begin
			s_nxt.timer_flag = bus_i.wdata[BIT_TIMER_FLAG];
			s_nxt.osc_flag   = bus_i.wdata[BIT_OSC_FLAG];
			if (bus_i.wdata[BIT_START] && (!s_r.running || s_r.refresh)) begin
				s_nxt.running = 1'b1;
				s_nxt.count   = {s_r.reload[6:0], LOW_START};
				s_nxt.refresh = 1'b0;
				psc_clr       = 1'b1;
			end
			if (bus_i.wdata[BIT_REFRESH]) begin
				s_nxt.refresh     = 1'b1;
				s_nxt.refresh_age = 2'h0;
			end
		end

		// Counting and time-out
		if (s_r.wd_rst) begin
			s_nxt.reload  = RELOAD_RST;
			s_nxt.count   = COUNT_RST;
			s_nxt.refresh = 1'b0;
			if (mcycle_i) begin
				if (s_r.wd_rst_cnt == s_r.wd_rst_len - 8'h01) begin
					s_nxt.wd_rst = 1'b0;
				end else begin
					s_nxt.wd_rst_cnt = s_r.wd_rst_cnt + 8'h01;
				end
			end
		end else if (s_r.running && !halt) begin
			if (s_r.count == WD_TRIP) begin
				s_nxt.wd_rst     = 1'b1;
				s_nxt.wd_rst_cnt = 8'h00;
				s_nxt.wd_rst_len = s_r.reload[BIT_PSEL] ? WD_RST_SLOW : WD_RST_FAST;
				s_nxt.timer_flag = 1'b1;
				s_nxt.running    = 1'b1;
				s_nxt.count      = COUNT_RST;
				s_nxt.reload     = RELOAD_RST;
				s_nxt.refresh    = 1'b0;
				psc_clr          = 1'b1;
			end else if (cnt_tick && !(wr_ctrl && bus_i.wdata[BIT_START])) begin
				s_nxt.count = s_r.count + 15'h0001;
			end
		end

		// External reset clears everything it owns
		if (ext_reset_i) begin
			s_nxt.running    = 1'b0;
			s_nxt.reload     = RELOAD_RST;
			s_nxt.refresh    = 1'b0;
			s_nxt.wd_rst     = 1'b0;
			s_nxt.count      = COUNT_RST;
			s_nxt.timer_flag = 1'b0;
			s_nxt.osc_flag   = 1'b0;
		end

		// Oscillator reset: timer flag kept, timer stopped, flag set (set wins)
		if (osc_rst) begin
			s_nxt.running  = 1'b0;
			s_nxt.reload   = RELOAD_RST;
			s_nxt.refresh  = 1'b0;
			s_nxt.wd_rst   = 1'b0;
			s_nxt.count    = COUNT_RST;
			s_nxt.osc_flag = 1'b1;
		end

		// Oscillator monitor sequence
		unique case (s_r.mon)
			MON_FAIL: begin
				if (!osc_fail) begin
					s_nxt.mon        = MON_SETTLE;
					s_nxt.settle_cnt = '0;
				end
			end
			MON_SETTLE: begin
				if (osc_fail) begin
					s_nxt.mon = s_r.wake_settle ? MON_WAKE_WAIT : MON_FAIL;
				end else if (s_r.settle_cnt == SETTLE_W'(RECOVER_CYCLES - 1)) begin
					s_nxt.mon         = MON_RUN;
					s_nxt.wake_settle = 1'b0;
				end else begin
					s_nxt.settle_cnt = s_r.settle_cnt + SETTLE_W'(1);
				end
			end
			MON_RUN: begin
				if (osc_fail) begin
					s_nxt.mon = MON_FAIL;
				end else if (powerdown_i) begin
					s_nxt.mon = MON_PDOWN;
				end
			end
			MON_PDOWN: begin
				if (wake_i) begin
					s_nxt.mon = MON_WAKE_WAIT;
				end
			end
			MON_WAKE_WAIT: begin
				if (!osc_fail) begin
					s_nxt.mon         = MON_SETTLE;
					s_nxt.wake_settle = 1'b1;
					s_nxt.settle_cnt  = '0;
				end
			end
		endcase

		// Registered outputs follow the next state so they change together
		s_nxt.clk_sel_rc = (s_nxt.mon != MON_RUN) && (s_nxt.mon != MON_PDOWN);
		s_nxt.osc_stop   = (s_nxt.mon == MON_PDOWN);
		s_nxt.wake_hold  = s_nxt.wake_settle || (s_nxt.mon == MON_WAKE_WAIT);
		s_nxt.sys_reset  = ext_reset_i || s_nxt.wd_rst || (s_nxt.mon == MON_FAIL)
			|| ((s_nxt.mon == MON_SETTLE) && !s_nxt.wake_settle);

		// Read data; the counter halves have no address
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				ADDR_CTRL:   s_nxt.rdata = {4'h0, s_r.osc_flag, s_r.timer_flag, s_r.refresh, s_r.running};
				ADDR_RELOAD: s_nxt.rdata = s_r.reload;
				default:     s_nxt.rdata = 8'h00;
			endcase
		end
	end

	// Power-on leaves the part in reset on the RC clock
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= ST_RST;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o      = s_r.rdata;
	assign sys_reset_o  = s_r.sys_reset;
	assign clk_sel_rc_o = s_r.clk_sel_rc;
	assign osc_stop_o   = s_r.osc_stop;
	assign wake_hold_o  = s_r.wake_hold;

	// Checks, sampled only on enabled cycles
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	property p_osc_flag;
		clk_en_i && (s_r.mon == MON_FAIL) |=> s_r.osc_flag;
	endproperty
	a_osc_flag: assert property (p_osc_flag) else $error("osc flag not set in failure");

	property p_trip;
		clk_en_i && s_r.running && !s_r.wd_rst && !halt && (s_r.count == WD_TRIP) && !ext_reset_i && !osc_rst
			|=> s_r.wd_rst && s_r.timer_flag && s_r.running && sys_reset_o;
	endproperty
	a_trip: assert property (p_trip) else $error("time-out did not enter watchdog reset");

	property p_no_stop;
		clk_en_i && s_r.running && !ext_reset_i && !osc_rst |=> s_r.running;
	endproperty
	a_no_stop: assert property (p_no_stop) else $error("watchdog stopped without reset");

	property p_halt;
		clk_en_i && s_r.running && halt && !s_r.wd_rst && !bus_i.wr && !ext_reset_i && !osc_rst
			&& (s_r.count != WD_TRIP) |=> $stable(s_r.count);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_preset;
		clk_en_i && !s_r.running && wr_ctrl && bus_i.wdata[BIT_START] && !ext_reset_i && !osc_rst
			|=> s_r.running && (s_r.count == {$past(s_r.reload[6:0]), LOW_START});
	endproperty
	a_preset: assert property (p_preset) else $error("start did not preset counter");

	property p_refresh_life;
		clk_en_i && s_r.refresh && mcycle_i && (s_r.refresh_age == REFRESH_LIFE) && !wr_ctrl |=> !s_r.refresh;
	endproperty
	a_refresh_life: assert property (p_refresh_life) else $error("refresh request outlived window");

	property p_wd_len;
		clk_en_i && s_r.wd_rst |-> (s_r.wd_rst_cnt < s_r.wd_rst_len)
			&& ((s_r.wd_rst_len == WD_RST_FAST) || (s_r.wd_rst_len == WD_RST_SLOW));
	endproperty
	a_wd_len: assert property (p_wd_len) else $error("watchdog reset length wrong");

	property p_ext_clear;
		clk_en_i && ext_reset_i && !osc_rst |=> !s_r.timer_flag && !s_r.osc_flag && sys_reset_o;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("external reset left flags set");

	property p_fail_clk;
		clk_en_i && (s_r.mon == MON_RUN) && osc_fail |=> clk_sel_rc_o && sys_reset_o;
	endproperty
	a_fail_clk: assert property (p_fail_clk) else $error("failure did not switch clock and reset");

	property p_hidden;
		clk_en_i && bus_i.rd && (bus_i.addr != ADDR_CTRL) && (bus_i.addr != ADDR_RELOAD) |=> rdata_o == 8'h00;
	endproperty
	a_hidden: assert property (p_hidden) else $error("unmapped read returned data");

	// Oscillator reset must stop the timer and cancel any watchdog reset in progress
	property p_osc_stop;
		clk_en_i && osc_rst |=> !s_r.running && !s_r.wd_rst && s_r.osc_flag;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator reset left watchdog running");

	property p_timer_keep;
		clk_en_i && osc_rst && s_r.timer_flag && !ext_reset_i && !wr_ctrl |=> s_r.timer_flag;
	endproperty
	a_timer_keep: assert property (p_timer_keep) else $error("oscillator reset lost timer flag");

	// Clock source and reset must leave the settle phase on the same edge
	property p_switch_back;
		clk_en_i && !ext_reset_i && (s_r.mon == MON_SETTLE) && !s_r.wake_settle
			|=> (clk_sel_rc_o == sys_reset_o);
	endproperty
	a_switch_back: assert property (p_switch_back) else $error("clock and reset released apart");

	property p_ext_hold;
		clk_en_i && ext_reset_i |=> sys_reset_o;
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("reset dropped during external request");

	property p_pdown_stop;
		clk_en_i && (s_r.mon == MON_PDOWN) && !wake_i |=> osc_stop_o && !clk_sel_rc_o;
	endproperty
	a_pdown_stop: assert property (p_pdown_stop) else $error("oscillators not stopped in power-down");

	c_trip: cover property (s_r.running && (s_r.count == WD_TRIP));
	c_refresh: cover property (wr_ctrl && bus_i.wdata[BIT_START] && s_r.running && s_r.refresh);
	c_recover: cover property ((s_r.mon == MON_SETTLE) ##1 (s_r.mon == MON_RUN));
	c_wake: cover property ((s_r.mon == MON_PDOWN) ##1 (s_r.mon == MON_WAKE_WAIT));
	c_ext_hold: cover property (ext_reset_i && (s_r.mon == MON_SETTLE));
endmodule

//--- tb/watchdog_and_osc_monitor_tb.sv
// Self-checking bench for the watchdog timer and oscillator monitor
`timescale 1ns/1ps
module watchdog_and_osc_monitor_tb;
	import wdog_pkg::*;

	// Short recovery phase keeps the run brief
	localparam int REC = 20;

	logic     sys_clk_i;
	logic     rstn_i;
	logic     clk_en_i;
	bus_req_s bus_i;
	logic [7:0] rdata_o;
	logic     mcycle_i = 1'b0;
	logic     idle_i;
	logic     powerdown_i;
	logic     wake_i;
	logic     ext_reset_i;
	logic     osc_tick_i = 1'b0;
	logic     rc_tick_i = 1'b0;
	logic     sys_reset_o;
	logic     clk_sel_rc_o;
	logic     osc_stop_o;
	logic     wake_hold_o;
	logic     osc_on;
	logic     rc_on;
	int       cyc = 0;
	int       mcnt = 0;
	int       failures;
	int       checked;

	watchdog_and_osc_monitor #(.RECOVER_CYCLES(REC)) dut_u (
		.sys_clk_i   (sys_clk_i),
		.rstn_i      (rstn_i),
		.clk_en_i    (clk_en_i),
		.bus_i       (bus_i),
		.rdata_o     (rdata_o),
		.mcycle_i    (mcycle_i),
		.idle_i      (idle_i),
		.powerdown_i (powerdown_i),
		.wake_i      (wake_i),
		.ext_reset_i (ext_reset_i),
		.osc_tick_i  (osc_tick_i),
		.rc_tick_i   (rc_tick_i),
		.sys_reset_o (sys_reset_o),
		.clk_sel_rc_o(clk_sel_rc_o),
		.osc_stop_o  (osc_stop_o),
		.wake_hold_o (wake_hold_o)
	);

	// Clock at 4 ns
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// Tick sources: machine cycle every 3 clocks, main osc every 2, RC every 4
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		mcycle_i <= (cyc % 3 == 0);
		if (cyc % 3 == 0) mcnt <= mcnt + 1;
		osc_tick_i <= osc_on && cyc[0];
		rc_tick_i <= rc_on && (cyc % 4 == 0);
	end

	// Verdict and end of run
	task end_sim();
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return sys_reset_o;
			1: return clk_sel_rc_o;
			2: return osc_stop_o;
			default: return wake_hold_o;
		endcase
	endfunction

	// Bounded wait for an output level; a used-up bound ends the run
	task wait_for(input int k, input logic lvl, input int bound, output int n);
		n = 0;
		#1;
		while (sig(k) !== lvl) begin
			if (n >= bound) begin
				check($sformatf("wait_output_%0d", k), sig(k), lvl);
				end_sim();
			end
			@(posedge sys_clk_i);
			#1;
			n++;
		end
	endtask

	// Output must hold one level for a number of cycles
	task stay(input int k, input logic lvl, input int cycles, input string name);
		int bad;
		bad = 0;
		repeat (cycles) begin
			@(posedge sys_clk_i);
			#1;
			if (sig(k) !== lvl) bad++;
		end
		check(name, bad, 0);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		bus_i.addr <= a;
		bus_i.wdata <= d;
		bus_i.wr <= 1'b1;
		@(posedge sys_clk_i);
		bus_i.wr <= 1'b0;
		#1;
	endtask

	// Read data is looked at only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge sys_clk_i);
		bus_i.addr <= a;
		bus_i.rd <= 1'b1;
		@(posedge sys_clk_i);
		bus_i.rd <= 1'b0;
		#1;
		check(name, rdata_o, exp);
	endtask

	task refresh();
		wr(ADDR_CTRL, 8'h02);
		wr(ADDR_CTRL, 8'h01);
	endtask

	task power_on();
		int n;
		check("reset_at_power_on", {sys_reset_o, clk_sel_rc_o}, 2'b11);
		wait_for(0, 1'b0, 500, n);
		check("clk_back_with_release", clk_sel_rc_o, 1'b0);
		check("recovery_long_enough", n >= REC, 1'b1);
		rd(ADDR_CTRL, 8'h08, "osc_flag_after_power_on");
		rd(ADDR_RELOAD, RELOAD_RST, "reload_reset");
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h00, "unmapped_read");
	endtask

	task flag_rw();
		wr(ADDR_CTRL, 8'h0c);
		rd(ADDR_CTRL, 8'h0c, "flags_set_by_write");
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CTRL, 8'h00, "flags_cleared_by_write");
	endtask

	// Pulse length in machine cycles of the watchdog reset
	task trip_len(input int lo, input int hi, input string name);
		int m;
		int n;
		m = mcnt;
		wait_for(0, 1'b0, 1000, n);
		check(name, (mcnt - m >= lo) && (mcnt - m <= hi), 1'b1);
	endtask

	task wd_trip();
		int m;
		int n;
		wr(ADDR_RELOAD, 8'h7f);
		wr(ADDR_CTRL, 8'h01);
		m = mcnt;
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CTRL, 8'h01, "start_not_stoppable");
		wait_for(0, 1'b1, 1000, n);
		check("trip_at_7ffc", (mcnt - m >= 250) && (mcnt - m <= 254), 1'b1);
		trip_len(7, 9, "fast_reset_length");
		rd(ADDR_CTRL, 8'h05, "timer_flag_and_running");
		rd(ADDR_RELOAD, 8'h00, "reload_cleared_by_trip");
	endtask

	task wd_refresh_idle();
		int m;
		int n;
		wr(ADDR_RELOAD, 8'h7f);
		refresh();
		repeat (3) begin
			stay(0, 1'b0, 600, "no_trip_with_refresh");
			refresh();
		end
		wr(ADDR_CTRL, 8'h02);
		rd(ADDR_CTRL, 8'h03, "refresh_request_pending");
		repeat (30) @(posedge sys_clk_i);
		rd(ADDR_CTRL, 8'h01, "refresh_request_expired");
		wr(ADDR_CTRL, 8'h01);
		stay(0, 1'b0, 300, "no_early_trip");
		@(posedge sys_clk_i);
		idle_i <= 1'b1;
		stay(0, 1'b0, 1200, "count_held_in_idle");
		@(posedge sys_clk_i);
		idle_i <= 1'b0;
		m = mcnt;
		wait_for(0, 1'b1, 1000, n);
		check("late_start_ignored", (mcnt - m >= 128) && (mcnt - m <= 145), 1'b1);
		trip_len(7, 9, "fast_reset_length_again");
	endtask

	task wd_slow();
		int m;
		int n;
		wr(ADDR_RELOAD, 8'hff);
		rd(ADDR_RELOAD, 8'hff, "reload_write_while_running");
		refresh();
		m = mcnt;
		wait_for(0, 1'b1, 13000, n);
		check("slow_trip", (mcnt - m >= 4020) && (mcnt - m <= 4050), 1'b1);
		trip_len(127, 129, "slow_reset_length");
	endtask

	task ext_reset();
		int n;
		@(posedge sys_clk_i);
		ext_reset_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		ext_reset_i <= 1'b0;
		wait_for(0, 1'b0, 10, n);
		rd(ADDR_CTRL, 8'h00, "ext_reset_clears_flags");
		rd(ADDR_RELOAD, 8'h00, "reload_cleared_by_ext");
	endtask

	task osc_fail_keep();
		int n;
		wr(ADDR_CTRL, 8'h05);
		@(posedge sys_clk_i);
		osc_on <= 1'b0;
		wait_for(0, 1'b1, 200, n);
		check("rc_clock_with_reset", clk_sel_rc_o, 1'b1);
		osc_on <= 1'b1;
		wait_for(0, 1'b0, 500, n);
		check("osc_recovery_length", n >= REC, 1'b1);
		rd(ADDR_CTRL, 8'h0c, "osc_reset_flags");
	endtask

	task osc_fail_ext();
		int n;
		@(posedge sys_clk_i);
		osc_on <= 1'b0;
		wait_for(0, 1'b1, 200, n);
		@(posedge sys_clk_i);
		ext_reset_i <= 1'b1;
		osc_on <= 1'b1;
		wait_for(1, 1'b0, 500, n);
		stay(0, 1'b1, 5, "reset_held_by_ext");
		@(posedge sys_clk_i);
		ext_reset_i <= 1'b0;
		wait_for(0, 1'b0, 10, n);
		rd(ADDR_CTRL, 8'h00, "ext_clears_osc_flag");
	endtask

	task power_down();
		int n;
		@(posedge sys_clk_i);
		powerdown_i <= 1'b1;
		wait_for(2, 1'b1, 20, n);
		osc_on <= 1'b0;
		rc_on <= 1'b0;
		stay(0, 1'b0, 100, "no_reset_in_power_down");
		@(posedge sys_clk_i);
		powerdown_i <= 1'b0;
		wake_i <= 1'b1;
		@(posedge sys_clk_i);
		wake_i <= 1'b0;
		wait_for(2, 1'b0, 20, n);
		check("wake_hold_on_rc", {wake_hold_o, clk_sel_rc_o}, 2'b11);
		osc_on <= 1'b1;
		rc_on <= 1'b1;
		wait_for(3, 1'b0, 500, n);
		check("wake_delay_and_no_reset", {n >= REC, sys_reset_o}, 2'b10);
	endtask

	// Main sequence
	initial begin
		rstn_i = 1'b0;
		clk_en_i = 1'b1;
		bus_i = '0;
		idle_i = 1'b0;
		powerdown_i = 1'b0;
		wake_i = 1'b0;
		ext_reset_i = 1'b0;
		osc_on = 1'b1;
		rc_on = 1'b1;
		failures = 0;
		checked = 0;
		repeat (4) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		#1;
		power_on();
		flag_rw();
		wd_trip();
		wd_refresh_idle();
		wd_slow();
		ext_reset();
		osc_fail_keep();
		osc_fail_ext();
		power_down();
		end_sim();
	end
endmodule
